// ---- design/pfl_pkg.sv ----
// constants, state codes and carrier types for the parallel flash loader
// assumes a 16-bit nor flash on a 24-bit word address bus
package pfl_pkg;

  localparam int ADDR_W   = 24;
  localparam int DATA_W   = 16;
  localparam int SCHEME_W = 4;

  // scheme code for the master loader; value is arbitrary
  localparam logic [SCHEME_W-1:0] SCHEME_MASTER = 4'h2;

  localparam logic [ADDR_W-1:0] START_ADDR     = 24'h000000;
  localparam logic [ADDR_W-1:0] WORD_TOTAL_DEF = 24'h000400;

  // link timing, oscillator cycles
  localparam int OSC_MHZ        = 40;
  localparam int OSC_PERIOD_NS  = 1000 / OSC_MHZ;
  localparam int CLKOUT_MAX_MHZ = 40;
  localparam int ACCESS_NS      = 100;
  localparam int ACCESS_CYC     = (ACCESS_NS + OSC_PERIOD_NS - 1) / OSC_PERIOD_NS;
  localparam int FRESET_NS      = 150;
  localparam int FRESET_CYC     = (FRESET_NS + OSC_PERIOD_NS - 1) / OSC_PERIOD_NS;
  localparam int SYNC_LAT       = 2;
  localparam int TMR_W          = 8;

  // flash strobes, all active low
  typedef struct packed {
    logic flashResetN;
    logic flashSelectN;
    logic flashOutputEnableN;
    logic addrValidN;
    logic flashWriteEnableN;
  } pfl_flash_ctl_s;

  localparam pfl_flash_ctl_s CTL_IDLE  = 5'h1f;
  localparam pfl_flash_ctl_s CTL_RESET = 5'h0f;
  localparam pfl_flash_ctl_s CTL_ADDR  = 5'h15;
  localparam pfl_flash_ctl_s CTL_READ  = 5'h13;

  typedef enum logic [3:0] {
    M_IDLE    = 4'h1,
    M_LOAD    = 4'h2,
    M_RELEASE = 4'h4,
    M_USER    = 4'h8
  } pfl_main_e;

  typedef enum logic [5:0] {
    L_IDLE   = 6'h01,
    L_FRESET = 6'h02,
    L_ADDR   = 6'h04,
    L_READ   = 6'h08,
    L_HAND   = 6'h10,
    L_END    = 6'h20
  } pfl_link_e;

endpackage

// ---- design/pfl_sync.sv ----
// two-flop level synchroniser, any width
// assumes each bit is a level or a word held stable across a handshake
`timescale 1ns/100ps
`default_nettype none
module pfl_sync #(
  parameter int W = 1
) (
  // destination clock
  input  wire logic         clk,
  // level in, level out
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] meta_r;

  // no reset: this also carries the reset itself into the link domain
  always_ff @(posedge clk)
  begin
    meta_r <= din;
    dout   <= meta_r;
  end

endmodule
`default_nettype wire

// ---- design/pfl_loader.sv ----
// master configuration loader reading a 16-bit parallel nor flash
// assumes oscClk is the free-running internal oscillator and that the
// config memory accepts one word per cfgWordValid pulse
`timescale 1ns/100ps
`default_nettype none
//
// Contract
// R1: device masters flash bus, fetches bitstream itself
// R2: drive 24-bit word address to flash
// R3: read 16-bit words over bidirectional bus
// R4: drive clock, reset, select, oe, avd, we
// R5: flash drives data only while oe low
// R6: ignore wait in config, monitor in user
// R7: flash reads async; writes always async
// R8: sync read data aligned to clock rise
// R9: flash supports 40 MHz continuous burst
// R10: output clock from oscillator, never above 40MHz
// R11: output clock times whole configuration cycle; code runs it only while loading and holds it low once the load ends
// R12: chain-in high, restart low tristates bus
// R13: 512-Mbit extra address driven externally
// R14: first chain-in tied low, outs feed ins
// R15: drive chain-out low once data captured
// R16: last chain-out unused or user pin
// R17: master scheme loads, slaves receive passively
// R18: restart, status, done, clock, data shared
// R19: slaves share low byte or split bytes
// R20: release done line; init when high
// R21: address increments sequentially until capture done
module pfl_loader
  import pfl_pkg::*;
#(
  parameter logic [ADDR_W-1:0] WORD_TOTAL = WORD_TOTAL_DEF
) (
  // system clock and reset
  input  wire logic                mclk,
  input  wire logic                reset,
  // internal oscillator, link clock
  input  wire logic                oscClk,
  // configuration control pins
  input  wire logic                configRestartN,
  input  wire logic                chainEnableInN,
  input  wire logic [SCHEME_W-1:0] schemeSelect,
  output logic                     chainEnableOutN,
  output logic                     chainEnableOutOe,
  // open-drain status and done lines
  input  wire logic                configStatusLineIn,
  output logic                     configStatusLineOut,
  output logic                     configStatusLineOe,
  input  wire logic                configDoneLineIn,
  output logic                     configDoneLineOut,
  output logic                     configDoneLineOe,
  // flash interface
  output logic                     configClockOut,
  output logic      [ADDR_W-1:0]   flashAddr,
  output var pfl_flash_ctl_s       flashCtl,
  output logic                     flashBusOe,
  input  wire logic [DATA_W-1:0]   flashDataIn,
  output logic      [DATA_W-1:0]   flashDataOut,
  output logic                     flashDataOe,
  input  wire logic                flashWait,
  // configuration memory side
  output logic      [DATA_W-1:0]   cfgWord,
  output logic                     cfgWordValid,
  output logic                     cfgLoading,
  output logic                     userMode,
  output logic                     userWait
);

  // mclk-side pin synchronisers
  logic [SCHEME_W+4:0] pinSync;
  logic                restartS;
  logic                chainInS;
  logic                doneInS;
  logic                statusInS;
  logic                waitS;
  logic [SCHEME_W-1:0] schemeS;

  pfl_sync #(.W(SCHEME_W + 5)) u_pin_sync (
    .clk  (mclk),
    .din  ({configRestartN, chainEnableInN, configDoneLineIn,
            configStatusLineIn, flashWait, schemeSelect}),
    .dout (pinSync)
  );

  assign {restartS, chainInS, doneInS, statusInS, waitS, schemeS} = pinSync;

  // link to mclk crossings
  logic linkDone_r;
  logic reqTog_r;
  logic linkDoneS;
  logic reqTogS;

  pfl_sync #(.W(2)) u_to_main (
    .clk  (mclk),
    .din  ({linkDone_r, reqTog_r}),
    .dout ({linkDoneS, reqTogS})
  );

  // mclk to link crossings
  logic runReq_r;
  logic busEn_r;
  logic ackTog_r;
  logic oscRst;
  logic runS;
  logic busEnS;
  logic ackTogS;

  pfl_sync #(.W(4)) u_to_link (
    .clk  (oscClk),
    .din  ({reset, runReq_r, busEn_r, ackTog_r}),
    .dout ({oscRst, runS, busEnS, ackTogS})
  );

  // flash data pins into the link domain
  logic [DATA_W-1:0] dataS;

  pfl_sync #(.W(DATA_W)) u_data_sync (
    .clk  (oscClk),
    .din  (flashDataIn),
    .dout (dataS)
  );

  // main sequencer, mclk domain
  pfl_main_e mainState_r;
  logic      isMaster;
  logic      startOk;

  assign isMaster = (schemeS == SCHEME_MASTER);
  assign startOk  = restartS && !chainInS && isMaster && statusInS;

  always_ff @(posedge mclk)
  begin
    if (reset || !restartS)
    begin
      mainState_r <= M_IDLE;
    end
    else
    begin
      case (mainState_r)
        M_IDLE:
        begin
          if (startOk)  // R1 R14 R17
          begin
            mainState_r <= M_LOAD;
          end
        end
        M_LOAD:
        begin
          if (!statusInS)
          begin
            mainState_r <= M_IDLE;
          end
          else if (linkDoneS)
          begin
            mainState_r <= M_RELEASE;
          end
        end
        M_RELEASE:
        begin
          if (doneInS)  // R20
          begin
            mainState_r <= M_USER;
          end
        end
        M_USER:
        begin
          mainState_r <= M_USER;
        end
        default:
        begin
          mainState_r <= M_IDLE;
        end
      endcase
    end
  end

  // run request and bus ownership toward the link side
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      runReq_r <= 1'b0;
      busEn_r  <= 1'b0;
    end
    else
    begin
      runReq_r <= (mainState_r == M_LOAD);
      busEn_r  <= isMaster && !(chainInS && !restartS);  // R12 R17
    end
  end

  // word handshake: the held word is stable until the ack returns
  logic reqSeen_r;
  logic [DATA_W-1:0] wordHold_r;

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      reqSeen_r    <= 1'b0;
      ackTog_r     <= 1'b0;
      cfgWord      <= '0;
      cfgWordValid <= 1'b0;
    end
    else
    begin
      reqSeen_r    <= reqTogS;
      cfgWordValid <= 1'b0;
      if (reqTogS != reqSeen_r)
      begin
        cfgWord      <= wordHold_r;  // R3 R19
        cfgWordValid <= (mainState_r == M_LOAD);
        ackTog_r     <= reqTogS;
      end
    end
  end

  // chain, status, done and user-mode pins
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      chainEnableOutN     <= 1'b1;
      chainEnableOutOe    <= 1'b1;
      configStatusLineOut <= 1'b0;
      configStatusLineOe  <= 1'b1;
      configDoneLineOut   <= 1'b0;
      configDoneLineOe    <= 1'b1;
      cfgLoading          <= 1'b0;
      userMode            <= 1'b0;
      userWait            <= 1'b0;
    end
    else
    begin
      configStatusLineOe <= !restartS;
      cfgLoading         <= (mainState_r == M_LOAD);
      userMode           <= (mainState_r == M_USER);
      // wait only counts once configuration is over
      userWait           <= (mainState_r == M_USER) && waitS;  // R6
      if (mainState_r == M_IDLE || mainState_r == M_LOAD)
      begin
        chainEnableOutN  <= 1'b1;
        configDoneLineOe <= 1'b1;
      end
      else
      begin
        chainEnableOutN  <= 1'b0;  // R15
        configDoneLineOe <= 1'b0;  // R20
      end
      // once in user mode the pin is handed over to user logic
      chainEnableOutOe <= (mainState_r != M_USER);  // R16
    end
  end

  // link engine, oscClk domain
  pfl_link_e              linkState_r;
  logic [ADDR_W-1:0]      addr_r;
  logic [ADDR_W-1:0]      wordCnt_r;
  logic [TMR_W-1:0]       tmr_r;
  logic                   clkOut_r;

  always_ff @(posedge oscClk)
  begin
    if (oscRst || !runS)
    begin
      linkState_r <= L_IDLE;
      linkDone_r  <= 1'b0;
      flashCtl    <= CTL_IDLE;
      addr_r      <= START_ADDR;
      wordCnt_r   <= '0;
      tmr_r       <= '0;
    end
    else
    begin
      case (linkState_r)
        L_IDLE:
        begin
          flashCtl    <= CTL_RESET;  // R4
          tmr_r       <= TMR_W'(FRESET_CYC);
          linkState_r <= L_FRESET;
        end
        L_FRESET:
        begin
          if (tmr_r == '0)
          begin
            flashCtl    <= CTL_IDLE;  // R7
            linkState_r <= L_ADDR;
          end
          else
          begin
            tmr_r <= tmr_r - 1'b1;
          end
        end
        L_ADDR:
        begin
          flashCtl    <= CTL_ADDR;
          tmr_r       <= TMR_W'(ACCESS_CYC + SYNC_LAT);
          linkState_r <= L_READ;
        end
        L_READ:
        begin
          flashCtl <= CTL_READ;  // R5
          if (tmr_r == '0)
          begin
            flashCtl    <= CTL_IDLE;
            linkState_r <= L_HAND;
          end
          else
          begin
            tmr_r <= tmr_r - 1'b1;
          end
        end
        L_HAND:
        begin
          if (ackTogS == reqTog_r)
          begin
            addr_r    <= addr_r + 1'b1;  // R21
            wordCnt_r <= wordCnt_r + 1'b1;
            if (wordCnt_r + 1'b1 == WORD_TOTAL)
            begin
              linkDone_r  <= 1'b1;
              linkState_r <= L_END;
            end
            else
            begin
              linkState_r <= L_ADDR;
            end
          end
        end
        L_END:
        begin
          flashCtl <= CTL_IDLE;
        end
        default:
        begin
          linkState_r <= L_IDLE;
        end
      endcase
    end
  end

  // toggle flop gives oscillator/2, well under the 40 MHz cap
  always_ff @(posedge oscClk)
  begin
    if (oscRst || !runS || linkState_r == L_END)
    begin
      clkOut_r <= 1'b0;
    end
    else
    begin
      clkOut_r <= ~clkOut_r;  // R10 R11
    end
  end

  always_ff @(posedge oscClk)
  begin
    if (oscRst)
    begin
      configClockOut <= 1'b0;
      flashBusOe     <= 1'b0;
      flashDataOut   <= '0;
      flashDataOe    <= 1'b0;
    end
    else
    begin
      configClockOut <= clkOut_r;
      // the loader only reads, so the data bus is never driven
      flashBusOe     <= busEnS;  // R1 R12
      flashDataOut   <= '0;
      flashDataOe    <= 1'b0;
    end
  end

  // capture and address registers, outside the run reset so that an
  // abort never breaks the toggle pairing with the mclk side
  always_ff @(posedge oscClk)
  begin
    if (oscRst)
    begin
      reqTog_r   <= 1'b0;
      wordHold_r <= '0;
      flashAddr  <= START_ADDR;
    end
    else if (runS && linkState_r == L_ADDR)
    begin
      flashAddr <= addr_r;  // R2
    end
    else if (runS && linkState_r == L_READ && tmr_r == '0)
    begin
      // wait pin is not consulted; a fixed access time is used
      wordHold_r <= dataS;  // R3 R6
      reqTog_r   <= ~reqTog_r;
    end
  end

endmodule
`default_nettype wire

// ---- sim/pfl_flash_model.sv ----
// behavioural 16-bit nor flash, asynchronous reads only
// assumes word content is address xor a key set by the bench
`timescale 1ns/100ps
`default_nettype none
module pfl_flash_model
  import pfl_pkg::*;
(
  // loader side; address lines beyond these 24 are left to the board
  input  wire logic [ADDR_W-1:0] flashAddr,
  input  wire pfl_flash_ctl_s    flashCtl,
  input  wire logic              flashBusOe,
  // content key
  input  wire logic [DATA_W-1:0] seedWord,
  // data toward the loader
  output logic      [DATA_W-1:0] dataOut
);
  logic [DATA_W-1:0] lastVal = '0;
  logic              drive;
  // no write path: the loader never writes, and the read mode stays async
  assign drive = flashBusOe && !flashCtl.flashSelectN && !flashCtl.flashOutputEnableN;
  // words settle within one link clock, inside a 40 MHz burst budget
  // released bus shows the inverse so a stale word never passes
  always_comb dataOut = drive ? (flashAddr[DATA_W-1:0] ^ seedWord) : ~lastVal;
  always @(dataOut) if (drive) lastVal = dataOut;
endmodule
`default_nettype wire

// ---- sim/pfl_loader_monitor.sv ----
// assertions on the loader pins and config-memory side
// assumes bind onto pfl_loader
`timescale 1ns/100ps
`default_nettype none
module pfl_loader_monitor
  import pfl_pkg::*;
(
  // clocks and reset
  input wire logic                mclk,
  input wire logic                reset,
  input wire logic                oscClk,
  // pins
  input wire logic [SCHEME_W-1:0] schemeSelect,
  input wire logic                chainEnableOutN,
  input wire logic                chainEnableOutOe,
  input wire logic                configDoneLineOe,
  input wire logic                configClockOut,
  input wire logic [ADDR_W-1:0]   flashAddr,
  input wire pfl_flash_ctl_s      flashCtl,
  // config memory side
  input wire logic                cfgWordValid,
  input wire logic                cfgLoading,
  input wire logic                userMode,
  input wire logic                userWait
);
  no_flash_write_a: assert property (@(posedge oscClk) disable iff (reset) flashCtl.flashWriteEnableN)
    else $error("write strobe low");
  clock_rate_a: assert property (@(posedge oscClk) disable iff (reset) configClockOut |=> !configClockOut)
    else $error("output clock too fast");
  read_select_a: assert property (@(posedge oscClk) disable iff (reset)
    !flashCtl.flashOutputEnableN |-> !flashCtl.flashSelectN)
    else $error("read without select");
  addr_step_a: assert property (@(posedge oscClk) disable iff (reset)
    !$stable(flashAddr) |-> flashAddr == $past(flashAddr) + 24'h1 || flashAddr == START_ADDR)
    else $error("address skipped");
  addr_hold_a: assert property (@(posedge oscClk) disable iff (reset)
    !flashCtl.flashOutputEnableN && !$past(flashCtl.flashOutputEnableN) |-> $stable(flashAddr))
    else $error("address moved in read");
  chain_done_a: assert property (@(posedge mclk) disable iff (reset) !chainEnableOutN |-> !configDoneLineOe)
    else $error("chain out before done release");
  user_chain_a: assert property (@(posedge mclk) disable iff (reset)
    $rose(userMode) |-> !chainEnableOutN ##1 !chainEnableOutOe)
    else $error("chain out pin not freed");
  wait_gate_a: assert property (@(posedge mclk) disable iff (reset) !userMode |-> !userWait)
    else $error("wait seen in config");
  word_pulse_a: assert property (@(posedge mclk) disable iff (reset) cfgWordValid |=> !cfgWordValid)
    else $error("word strobe too long");
  scheme_gate_a: assert property (@(posedge mclk) disable iff (reset)
    !cfgLoading && schemeSelect != SCHEME_MASTER |=> !cfgLoading)
    else $error("load in slave scheme");
  cover property (@(posedge mclk) cfgWordValid);
  cover property (@(posedge mclk) $fell(chainEnableOutN));
  cover property (@(posedge mclk) $rose(userMode));
endmodule
bind pfl_loader pfl_loader_monitor i_mon (
  .mclk(mclk), .reset(reset), .oscClk(oscClk), .schemeSelect(schemeSelect),
  .chainEnableOutN(chainEnableOutN), .chainEnableOutOe(chainEnableOutOe),
  .configDoneLineOe(configDoneLineOe), .configClockOut(configClockOut),
  .flashAddr(flashAddr), .flashCtl(flashCtl), .cfgWordValid(cfgWordValid),
  .cfgLoading(cfgLoading), .userMode(userMode), .userWait(userWait)
);
`default_nettype wire

// ---- sim/tb_pfl_loader.sv ----
// self-checking bench for the parallel flash loader
// assumes the flash model and the monitor are compiled first
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin nTests++; if ((a) !== (e)) begin nFail++; $display("BAD t=%0t got=%h exp=%h", $time, a, e); end end
`define WAITC(c) begin int k; for (k = 0; k < 9000 && !(c); k++) @(posedge mclk); if (!(c)) begin nFail++; testDone(); end end
module tb_pfl_loader
  import pfl_pkg::*;
;
  localparam logic [ADDR_W-1:0] WT = 24'h000004;
  logic mclk = 0, reset = 1, oscClk = 0, restartN = 0, chainInN = 0, doneRel = 0, flashWait = 0;
  logic [SCHEME_W-1:0] scheme = 4'h0;
  logic [DATA_W-1:0] seed = 16'h0000, flashData, cfgWord, dataOut;
  logic [ADDR_W-1:0] flashAddr;
  pfl_flash_ctl_s flashCtl;
  logic chOutN, chOutOe, stOut, stOe, dnOut, dnOe, cclk, busOe, dataOe, wordValid, loading, userMode;
  logic userWait;
  logic [2:0] waitPipe = 3'h0;
  logic [DATA_W-1:0] expQ[$];
  logic [DATA_W-1:0] expW;
  int nFail = 0, nTests = 0;

  always #2 mclk = ~mclk;
  always #80 oscClk = ~oscClk;
  // shared open-drain status and done; a second device holds done low
  pfl_loader #(.WORD_TOTAL(WT)) i_dut (
    .mclk(mclk), .reset(reset), .oscClk(oscClk), .configRestartN(restartN),
    .chainEnableInN(chainInN), .schemeSelect(scheme), .chainEnableOutN(chOutN),
    .chainEnableOutOe(chOutOe), .configStatusLineIn(!(stOe && !stOut)),
    .configStatusLineOut(stOut), .configStatusLineOe(stOe),
    .configDoneLineIn(doneRel && !(dnOe && !dnOut)), .configDoneLineOut(dnOut),
    .configDoneLineOe(dnOe), .configClockOut(cclk), .flashAddr(flashAddr),
    .flashCtl(flashCtl), .flashBusOe(busOe), .flashDataIn(flashData),
    .flashDataOut(dataOut), .flashDataOe(dataOe), .flashWait(flashWait),
    .cfgWord(cfgWord), .cfgWordValid(wordValid), .cfgLoading(loading),
    .userMode(userMode), .userWait(userWait)
  );
  pfl_flash_model i_flash (
    .flashAddr(flashAddr), .flashCtl(flashCtl), .flashBusOe(busOe),
    .seedWord(seed), .dataOut(flashData)
  );
  // wait toggles at random; the loader must not care during config
  always @(posedge mclk) flashWait <= 1'($urandom_range(0, 1));
  // same two-stage delay as the pin synchroniser, plus the output flop
  always @(posedge mclk) waitPipe <= {waitPipe[1:0], flashWait};

  always @(negedge mclk)
  begin
    if (wordValid === 1'b1)
    begin
      if (expQ.size() == 0) `CHK(expQ.size(), 1)
      else
      begin
        expW = expQ.pop_front();
        `CHK(cfgWord, expW)
      end
    end
    if (userMode === 1'b1) `CHK(userWait, waitPipe[2])
  end

  task automatic expectAll();
    int i;
    for (i = 0; i < WT; i++) expQ.push_back(START_ADDR[DATA_W-1:0] + i[DATA_W-1:0] ^ seed);
  endtask

  task automatic testDone();
    $display("checks %0d, mismatches %0d", nTests, nFail);
    if (nFail == 0 && nTests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial
  begin
    seed = 16'($urandom(74));
    // reset spans several link clocks so the link side sees it too
    repeat (12) @(posedge oscClk);
    @(posedge mclk);
    reset <= 0;
    restartN <= 1;
    repeat (300) @(posedge mclk);
    #1;
    `CHK(loading, 1'b0)
    `CHK(busOe, 1'b0)
    `CHK(flashCtl, CTL_IDLE)
    $display("slave scheme test ended");
    @(posedge mclk);
    restartN <= 0;
    chainInN <= 1;
    scheme <= SCHEME_MASTER;
    repeat (300) @(posedge mclk);
    #1;
    `CHK(busOe, 1'b0)
    @(posedge mclk);
    restartN <= 1;
    repeat (300) @(posedge mclk);
    #1;
    `CHK(loading, 1'b0)
    `CHK(busOe, 1'b1)
    $display("chain hold test ended");
    @(posedge mclk);
    chainInN <= 0;
    expectAll();
    `WAITC(expQ.size() <= WT - 2)
    restartN <= 0;
    repeat (400) @(posedge mclk);
    #1;
    `CHK(loading, 1'b0)
    `CHK(stOe, 1'b1)
    expQ.delete();
    $display("abort test ended");
    @(posedge mclk);
    restartN <= 1;
    expectAll();
    `WAITC(chOutN === 1'b0)
    #1;
    `CHK(expQ.size(), 0)
    `CHK(dnOe, 1'b0)
    `CHK(dnOut, 1'b0)
    repeat (100) @(posedge mclk);
    #1;
    `CHK(userMode, 1'b0)
    @(posedge mclk);
    doneRel <= 1;
    `WAITC(userMode === 1'b1)
    repeat (40) @(posedge mclk);
    #1;
    `CHK(chOutOe, 1'b0)
    `CHK(cclk, 1'b0)
    `CHK(dataOe, 1'b0)
    $display("load test ended");
    testDone();
  end
endmodule
`default_nettype wire
